//--- design/dccl_pkg.sv
package dccl_pkg;

   // Mode pin codes as sampled after init_done rises.
   typedef enum logic [2:0]
   {
      DCCL_MODE_MSER = 3'h0,
      DCCL_MODE_SPER = 3'h3,
      DCCL_MODE_MPAR = 3'h4,
      DCCL_MODE_APER = 3'h5,
      DCCL_MODE_SSER = 3'h7
   } dccl_mode_t;

   // Preamble that opens the bitstream header.
   localparam logic [3:0] PREAMBLE = 4'h2;
   // Width of the stored length count.
   localparam int LEN_W = 24;
   // Configuration clocks from length match to I/O release.
   localparam logic [1:0] RELEASE_CLKS = 2'h2;
   // Further clocks from length match to the finish point.
   localparam logic [2:0] FINISH_CLKS = 3'h4;
   // Index of the last bit in one configuration byte.
   localparam logic [2:0] BYTE_LAST = 3'h7;
   // Own frame count default, a plain value.
   localparam logic [23:0] OWN_BITS_DEF = 24'h00_0040;
   // Master clock divider: half period in system clocks.
   localparam logic [3:0] MCLK_HALF = 4'h6;
   // Byte address width for master parallel loading.
   localparam int ADDR_W = 22;

   // Bus decode: register offsets (byte addresses).
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_IRQ = 4'h8;
   localparam logic [3:0] REG_MASK = 4'hC;
   // Interrupt event bit positions.
   localparam int EV_MATCH = 0;
   localparam int EV_FINISH = 1;
   localparam int EV_BYTE = 2;
   localparam int EV_N = 3;

   // Bus request bundle.
   typedef struct packed
   {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } dccl_req_t;

endpackage

//--- design/dccl_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser for a group of pin inputs.
module dccl_sync #(parameter int W = 1)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // First stage; only the second stage reads it.
   logic [W-1:0] meta;

   // Both stages reset to zero and then follow the pin.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta <= '0;
         q_o <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule
`default_nettype wire

//--- design/dccl_top.sv
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module dccl_top
(
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic [3:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   output logic IRQ_O,
   input wire logic INIT_DONE_I,
   input wire logic [2:0] MODE_SELECT_PINS_I,
   output logic MODE1_O,
   output logic MODE1_OE_O,
   input wire logic MODE1_USER_I,
   input wire logic MODE1_USER_OE_I,
   input wire logic CFG_CLK_I,
   output logic CFG_CLK_O,
   output logic CFG_CLK_OE_O,
   input wire logic CFG_DATA_I,
   input wire logic [7:0] PDATA_I,
   output logic [7:0] PDATA_O,
   output logic PDATA_OE_O,
   input wire logic CS_I,
   input wire logic WS_I,
   input wire logic RS_I,
   output logic WRITE_READY_FLAG_O,
   output logic WRITE_READY_WEAK_O,
   output logic ADDRESS_ADVANCE_STROBE_O,
   output logic [dccl_pkg::ADDR_W-1:0] CFG_ADDR_O,
   output logic CHAIN_DATA_OUT_O,
   output logic CONFIG_COMPLETE_O,
   output logic CONFIG_COMPLETE_OE_O,
   output logic USER_IO_EN_O,
   output logic READBACK_OK_O
);
   import dccl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   // Synchronised copies of the asynchronous pins.
   logic [16:0] pins_s;
   logic init_s;
   logic configuration_clock_in_s;
   logic din_s;
   logic cs_s;
   logic ws_s;
   logic rs_s;
   logic [2:0] mode_s;
   logic [7:0] pdata_s;

   // Every configuration pin passes two flip-flops before use; the bus and MODE1 user inputs are used directly.
   dccl_sync #(.W(17)) u_sync
   (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .d_i({INIT_DONE_I, CFG_CLK_I, CFG_DATA_I, CS_I, WS_I, RS_I, MODE_SELECT_PINS_I,
            PDATA_I}),
      .q_o(pins_s)
   );
   assign {init_s, configuration_clock_in_s, din_s, cs_s, ws_s, rs_s, mode_s, pdata_s} = pins_s;

   ////////////////////////////////////////////////////////////////////////////
   // Mode capture.

   // Latched mode and a flag that it is valid.
   dccl_mode_t mode;
   logic mode_valid;
   logic init_q;
   // Master modes and async peripheral drive the clock themselves.
   logic drive_clk;

   // Mode is sampled on the first cycle init done is seen high.
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         init_q <= 1'b0;
         mode_valid <= 1'b0;
         mode <= DCCL_MODE_SSER;
      end
      else
      begin
         init_q <= init_s;
         if (init_s && !init_q && !mode_valid)
         begin
            mode <= dccl_mode_t'(mode_s);
            mode_valid <= 1'b1;
         end
      end
   end
   assign drive_clk = mode_valid && (mode == DCCL_MODE_MSER || mode == DCCL_MODE_MPAR ||
                                     mode == DCCL_MODE_APER);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration clock: own divider or sampled pin.

   logic [3:0] div_cnt;
   logic configuration_clock_gen;
   logic run_clk;
   logic configuration_clock_q;
   logic configuration_clock_rise;
   logic configuration_clock_cur;

   // The divider toggles the driven clock while clocking is needed.
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         div_cnt <= 4'h0;
         configuration_clock_gen <= 1'b0;
      end
      else if (run_clk && div_cnt == MCLK_HALF - 4'h1)
      begin
         div_cnt <= 4'h0;
         configuration_clock_gen <= ~configuration_clock_gen;
      end
      else
      begin
         div_cnt <= run_clk ? div_cnt + 4'h1 : 4'h0;
      end
   end
   assign configuration_clock_cur = drive_clk ? configuration_clock_gen : configuration_clock_in_s;

   // Edge detect on the selected clock; only rising edges act.
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         configuration_clock_q <= 1'b0;
      end
      else
      begin
         configuration_clock_q <= configuration_clock_cur;
      end
   end
   assign configuration_clock_rise = mode_valid && configuration_clock_cur && !configuration_clock_q;
   assign CFG_CLK_O = configuration_clock_gen;
   assign CFG_CLK_OE_O = drive_clk;

   ////////////////////////////////////////////////////////////////////////////
   // Byte feed for parallel modes, giving one serial bit per clock.

   logic par_mode;
   logic [7:0] shreg;
   logic [2:0] bit_idx;
   logic byte_full;
   logic ws_q;
   logic ser_bit;
   logic byte_ev;

   assign par_mode = mode == DCCL_MODE_MPAR || mode == DCCL_MODE_APER ||
                     mode == DCCL_MODE_SPER;

   // A byte loads on write end or on a configuration clock edge and shifts out MSB first.
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         shreg <= 8'h00;
         bit_idx <= 3'h0;
         byte_full <= 1'b0;
         ws_q <= 1'b1;
         CFG_ADDR_O <= '0;
         ADDRESS_ADVANCE_STROBE_O <= 1'b0;
         byte_ev <= 1'b0;
      end
      else
      begin
         ws_q <= ws_s;
         byte_ev <= 1'b0;
         ADDRESS_ADVANCE_STROBE_O <= 1'b0;
         if (!byte_full && par_mode && mode_valid)
         begin
            // Peripheral write ends on the rising write strobe.
            if (mode == DCCL_MODE_APER && !cs_s && ws_s && !ws_q)
            begin
               shreg <= pdata_s;
               byte_full <= 1'b1;
               byte_ev <= 1'b1;
            end
            // Master and synchronous parallel take the byte on a clock edge.
            else if (mode != DCCL_MODE_APER && configuration_clock_rise)
            begin
               shreg <= pdata_s;
               byte_full <= 1'b1;
               byte_ev <= 1'b1;
               if (mode == DCCL_MODE_MPAR)
               begin
                  // Strobe rises this cycle, the address moves next cycle.
                  ADDRESS_ADVANCE_STROBE_O <= 1'b1;
               end
            end
         end
         else if (byte_full && configuration_clock_rise)
         begin
            shreg <= {shreg[6:0], 1'b0};
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == BYTE_LAST)
            begin
               byte_full <= 1'b0;
            end
         end
         if (ADDRESS_ADVANCE_STROBE_O)
         begin
            CFG_ADDR_O <= CFG_ADDR_O + 1'b1;
         end
      end
   end
   assign ser_bit = par_mode ? shreg[7] : din_s;

   // Ready while the shifter can take a byte.
   assign WRITE_READY_FLAG_O = init_s && !byte_full;
   // A weak pull-up stands in until init done is high.
   assign WRITE_READY_WEAK_O = !init_s;
   // Async peripheral read returns the ready state on bit 7.
   assign PDATA_O = {WRITE_READY_FLAG_O, 7'h00};
   assign PDATA_OE_O = mode_valid && mode == DCCL_MODE_APER && !cs_s && !rs_s;

   ////////////////////////////////////////////////////////////////////////////
   // Header parser and chain output.

   typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_LEN, ST_OWN, ST_PASS} dccl_hdr_t;
   dccl_hdr_t hst;
   logic [3:0] pre_sh;
   logic [4:0] len_idx;
   logic [LEN_W-1:0] len_val;
   logic [LEN_W-1:0] own_left;
   logic [LEN_W-1:0] clk_cnt;
   logic [LEN_W-1:0] own_bits;
   logic chain_bit;

   // Clocks and preamble search start from init done.
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         hst <= ST_IDLE;
         pre_sh <= 4'hF;
         len_idx <= 5'h0;
         len_val <= '0;
         own_left <= '0;
         chain_bit <= 1'b1;
      end
      else if (configuration_clock_rise && (!par_mode || byte_full))
      begin
         case (hst)
            ST_IDLE, ST_PRE:
            begin
               // Header bits are passed through while hunting.
               chain_bit <= ser_bit;
               pre_sh <= {pre_sh[2:0], ser_bit};
               hst <= ST_PRE;
               if ({pre_sh[2:0], ser_bit} == PREAMBLE)
               begin
                  hst <= ST_LEN;
                  len_idx <= 5'h0;
               end
            end
            ST_LEN:
            begin
               chain_bit <= ser_bit;
               len_val <= {len_val[LEN_W-2:0], ser_bit};
               len_idx <= len_idx + 5'h1;
               if (len_idx == 5'(LEN_W - 1))
               begin
                  hst <= ST_OWN;
                  own_left <= own_bits;
               end
            end
            ST_OWN:
            begin
               chain_bit <= 1'b1;
               own_left <= own_left - 1'b1;
               if (own_left == 24'h00_0001)
               begin
                  hst <= ST_PASS;
               end
            end
            ST_PASS:
            begin
               chain_bit <= ser_bit;
            end
            default:
            begin
               hst <= ST_IDLE;
            end
         endcase
      end
   end
   assign CHAIN_DATA_OUT_O = chain_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Length match, start-up and finish point.

   logic matched;
   logic [2:0] post_cnt;
   logic finished;
   logic match_ev;
   logic finish_ev;

   // Count configuration clocks from init done up to the match; match starts start-up.
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         clk_cnt <= '0;
         matched <= 1'b0;
         post_cnt <= 3'h0;
         finished <= 1'b0;
         match_ev <= 1'b0;
         finish_ev <= 1'b0;
      end
      else
      begin
         match_ev <= 1'b0;
         finish_ev <= 1'b0;
         if (configuration_clock_rise && !matched)
         begin
            clk_cnt <= clk_cnt + 1'b1;
            // Same edge in every device, as all share one clock and count.
            if (hst != ST_IDLE && hst != ST_PRE && hst != ST_LEN &&
                clk_cnt + 1'b1 == len_val)
            begin
               matched <= 1'b1;
               match_ev <= 1'b1;
            end
         end
         else if (configuration_clock_rise && matched && !finished)
         begin
            post_cnt <= post_cnt + 3'h1;
            if (post_cnt + 3'h1 == FINISH_CLKS)
            begin
               finished <= 1'b1;
               finish_ev <= 1'b1;
            end
         end
      end
   end
   // Master keeps clocking until the finish point; slaves rely on the lead.
   assign run_clk = drive_clk && !finished;
   // I/O release and complete flag follow two clocks after the last bit.
   assign USER_IO_EN_O = matched && post_cnt >= 3'(RELEASE_CLKS);
   assign CONFIG_COMPLETE_O = USER_IO_EN_O;
   assign CONFIG_COMPLETE_OE_O = 1'b1;
   // Without the finish point readback and test ops stay locked.
   assign READBACK_OK_O = finished;
   // After loading the middle mode pin is a bare user output.
   assign MODE1_O = MODE1_USER_I;
   assign MODE1_OE_O = finished && MODE1_USER_OE_I;

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave: control, status, interrupt status and mask.

   logic [EV_N-1:0] irq_stat;
   logic [EV_N-1:0] irq_mask;
   logic [EV_N-1:0] ev;
   logic ack;

   assign ev = {byte_ev, finish_ev, match_ev};
   // One wait cycle per access, then the answer.
   assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack;

   // Control holds own frame bit count; interrupt status bits are sticky, write one clears.
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         ack <= 1'b0;
         own_bits <= OWN_BITS_DEF;
         irq_mask <= '0;
         irq_stat <= '0;
         AVS_READDATA_O <= 32'h0000_0000;
      end
      else
      begin
         ack <= (AVS_READ_I || AVS_WRITE_I) && !ack;
         irq_stat <= irq_stat | ev;
         // A write lands only at the edge where waitrequest is seen low.
         if (AVS_WRITE_I && ack)
         begin
            case (AVS_ADDRESS_I)
               REG_CTRL: own_bits <= AVS_WRITEDATA_I[LEN_W-1:0];
               REG_IRQ: irq_stat <= (irq_stat & ~AVS_WRITEDATA_I[EV_N-1:0]) | ev;
               REG_MASK: irq_mask <= AVS_WRITEDATA_I[EV_N-1:0];
               default: ;
            endcase
         end
         if (AVS_READ_I && !ack)
         begin
            case (AVS_ADDRESS_I)
               REG_CTRL: AVS_READDATA_O <= {8'h00, own_bits};
               REG_STAT: AVS_READDATA_O <= {20'h0_0000, 1'(mode_valid), mode, 1'(finished),
                                            1'(matched), WRITE_READY_FLAG_O, 5'(hst)};
               REG_IRQ: AVS_READDATA_O <= {29'h0000_0000, irq_stat};
               REG_MASK: AVS_READDATA_O <= {29'h0000_0000, irq_mask};
               default: AVS_READDATA_O <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign IRQ_O = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   // One header step taken while in the own frames.
   logic own_step;
   assign own_step = hst == ST_OWN && configuration_clock_rise && (!par_mode || byte_full);

   a_ready_before_init: assert property (@(posedge MCLK_I) disable iff (RST_I)
      !init_s |-> WRITE_READY_WEAK_O && !WRITE_READY_FLAG_O)
      else $error("ready not weak high before init");
   a_d7_ready: assert property (@(posedge MCLK_I) disable iff (RST_I)
      PDATA_OE_O |-> PDATA_O[7] == WRITE_READY_FLAG_O)
      else $error("D7 does not show ready");
   a_strobe_before_addr: assert property (@(posedge MCLK_I) disable iff (RST_I)
      $changed(CFG_ADDR_O) |-> $past(ADDRESS_ADVANCE_STROBE_O))
      else $error("address changed without strobe");
   a_ready_flag: assert property (@(posedge MCLK_I) disable iff (RST_I)
      WRITE_READY_FLAG_O |-> init_s && !byte_full)
      else $error("ready while busy");
   // The last length bit still passes through for one clock, so only a step
   // taken inside the own frames must be followed by a forced high.
   a_own_high: assert property (@(posedge MCLK_I) disable iff (RST_I)
      own_step |=> CHAIN_DATA_OUT_O)
      else $error("chain out not high in own frames");
   a_release_two: assert property (@(posedge MCLK_I) disable iff (RST_I)
      $rose(matched) |-> !USER_IO_EN_O)
      else $error("I/O released too early");
   a_finish_gate: assert property (@(posedge MCLK_I) disable iff (RST_I)
      !finished |-> !READBACK_OK_O && !MODE1_OE_O)
      else $error("readback enabled without finish");
   // The driven clock must freeze once the finish point is reached.
   a_clk_stop: assert property (@(posedge MCLK_I) disable iff (RST_I)
      finished |=> $stable(CFG_CLK_O))
      else $error("master clock runs after finish");
   c_match: cover property (@(posedge MCLK_I) disable iff (RST_I) $rose(matched));
   c_finish: cover property (@(posedge MCLK_I) disable iff (RST_I) $rose(finished));
   c_pass: cover property (@(posedge MCLK_I) disable iff (RST_I) hst == ST_PASS);
endmodule
`default_nettype wire

//--- tb/dccl_lead.sv
`timescale 1ns/1ns
`default_nettype none
// Lead device model: serves the bitstream on the serial data line and makes
// the configuration clock in the modes where the far side owns it.
module dccl_lead
(
   input wire logic link_i,
   output logic clk_o,
   output logic data_o
);
   // Stream served MSB first, and the rising edges seen since it was armed.
   logic [63:0] stream;
   int idx;

   initial
   begin
      clk_o = 1'b0;
      data_o = 1'b1;
      stream = 64'h0;
      idx = 0;
   end

   // Arms a stream; the first bit is set up well before the first edge.
   task automatic load(input logic [63:0] v);
      stream = v;
      idx = 0;
      data_o = v[63];
   endtask

   // One 125 ns pulse; between calls the clock stands still low.
   // The rise comes 1 ns late so it never lands on a system clock edge.
   task automatic pulse();
      #1;
      clk_o = 1'b1;
      #62;
      clk_o = 1'b0;
      #62;
   endtask

   // Extra pulse after the lead's release: a 2-bit shifter on a 5 MHz
   // oscillator gives one oscillator period of output. That output is active
   // low on a line that idles high; this line idles low, so it is inverted.
   task automatic extra_pulse();
      logic [1:0] sh;
      sh = 2'b00;
      repeat (3)
      begin
         #99;
         sh = {sh[0], 1'b1};
         clk_o = sh[0] && !sh[1];
         #101;
      end
   endtask

   // Counts rising edges on the wire, whoever drives it.
   always @(posedge link_i)
      idx <= idx + 1;

   // Changing data on the falling edge keeps it steady round the rising one.
   // Past the end the line toggles, so a stale bit never passes for data.
   always @(negedge link_i)
      data_o <= (idx < 64) ? stream[63 - idx] : ~data_o;
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import dccl_pkg::*;

   // Leading ones, preamble, length 0x30, eight own bits, eight passed bits.
   localparam logic [63:0] STREAM = {4'hF, 4'h2, 24'h00_0030, 8'hA5, 8'h3C, 16'hA5A5};

   logic mclk, rst, rd, wr, wreq, irq, init_done, m1_user, m1_user_oe;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [2:0] mode;
   logic [7:0] pdata, pdata_o;
   logic cs_n, ws_n, rs_n, pdata_oe, ready, ready_weak, stb, chain, done_o, done_oe;
   logic user_io, rb_ok, configuration_clock_o, configuration_clock_oe, lead_clk, lead_data, configuration_clock_w, mode1_o, mode1_oe;
   logic [ADDR_W-1:0] cfg_addr, prev_addr;
   logic prev_stb;
   int mismatches, n_tests, n_adv;

   // The shared clock wire: the device drives it only while enabled.
   assign configuration_clock_w = configuration_clock_oe ? configuration_clock_o : lead_clk;

   dccl_top dccl_top_inst
   (
      .MCLK_I(mclk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(wreq), .IRQ_O(irq), .INIT_DONE_I(init_done),
      .MODE_SELECT_PINS_I(mode), .MODE1_O(mode1_o), .MODE1_OE_O(mode1_oe),
      .MODE1_USER_I(m1_user), .MODE1_USER_OE_I(m1_user_oe), .CFG_CLK_I(configuration_clock_w),
      .CFG_CLK_O(configuration_clock_o), .CFG_CLK_OE_O(configuration_clock_oe), .CFG_DATA_I(lead_data),
      .PDATA_I(pdata), .PDATA_O(pdata_o), .PDATA_OE_O(pdata_oe), .CS_I(cs_n),
      .WS_I(ws_n), .RS_I(rs_n), .WRITE_READY_FLAG_O(ready),
      .WRITE_READY_WEAK_O(ready_weak), .ADDRESS_ADVANCE_STROBE_O(stb),
      .CFG_ADDR_O(cfg_addr), .CHAIN_DATA_OUT_O(chain), .CONFIG_COMPLETE_O(done_o),
      .CONFIG_COMPLETE_OE_O(done_oe), .USER_IO_EN_O(user_io), .READBACK_OK_O(rb_ok)
   );

   dccl_lead dccl_lead_inst
   (
      .link_i(configuration_clock_w),
      .clk_o(lead_clk),
      .data_o(lead_data)
   );

   ////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wrap_up();
      if (mismatches == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // A hang shows up as a missing verdict, so cut it short here.
   initial
   begin
      #200000;
      mismatches++;
      wrap_up();
   end

   // One bus access; the request stands until waitrequest is sampled low.
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rv);
      int n;
      n = 0;
      @(posedge mclk);
      addr <= a;
      wdata <= wd;
      wr <= w;
      rd <= ~w;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (wreq !== 1'b0 && n < 100);
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 100)
         chk("bus answer", 1, 0);
   endtask

   // Every move of the load address must follow a strobe one cycle earlier.
   always @(posedge mclk)
   begin
      prev_addr <= cfg_addr;
      prev_stb <= stb;
      if (!rst && cfg_addr !== prev_addr)
      begin
         n_adv++;
         chk("strobe before address", 1, prev_stb);
      end
   end

   task automatic do_reset();
      @(posedge mclk);
      rst <= 1'b1;
      init_done <= 1'b0;
      cs_n <= 1'b1;
      ws_n <= 1'b1;
      rs_n <= 1'b1;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////
   // Slave serial load with eight own bits, n_clk clock pulses and, if asked,
   // the lead's extra pulse from its 2-bit shifter.
   task automatic load_slave(input int n_clk, input logic fin_exp, input logic extra);
      logic [31:0] v;
      do_reset();
      bus(REG_CTRL, 1'b1, 32'h0000_0008, v);
      mode <= 3'h7;
      dccl_lead_inst.load(STREAM);
      init_done <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("mode1 enable early", 0, mode1_oe);
      chk("clock enable slave", 0, configuration_clock_oe);
      bus(REG_STAT, 1'b0, 32'h0, v);
      chk("latched mode", 32'h0000_000F, v[11:8]);
      for (int k = 1; k <= n_clk; k++)
      begin
         dccl_lead_inst.pulse();
         if (k > 32 && k <= 40)
            chk("chain out own", 1, chain);
         if (k > 40 && k <= 48)
            chk("chain out passed", STREAM[64 - k], chain);
         if (k == 47 || k == 48)
         begin
            bus(REG_STAT, 1'b0, 32'h0, v);
            chk("length match", k == 48, v[6]);
         end
         if (k == 49 || k == 50)
            chk("user io", k == 50, user_io);
         if (k == 51)
            chk("finish early", 0, rb_ok);
      end
      if (extra)
         dccl_lead_inst.extra_pulse();
      repeat (20) @(posedge mclk);
      chk("finish", fin_exp, rb_ok);
      chk("mode1 enable end", fin_exp, mode1_oe);
      chk("complete", 1, done_o);
   endtask

   // Asynchronous peripheral byte write, status on D7, byte interrupt.
   task automatic async_periph();
      logic [31:0] v;
      int n;
      do_reset();
      chk("weak pull before init", 1, ready_weak);
      bus(REG_MASK, 1'b1, 32'h0000_0004, v);
      mode <= 3'h5;
      init_done <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("weak pull after init", 0, ready_weak);
      chk("ready idle", 1, ready);
      chk("clock enable periph", 1, configuration_clock_oe);
      pdata <= 8'hA5;
      cs_n <= 1'b0;
      ws_n <= 1'b0;
      repeat (4) @(posedge mclk);
      ws_n <= 1'b1;
      n = 0;
      while (ready !== 1'b0 && n < 50)
      begin
         @(posedge mclk);
         n++;
      end
      rs_n <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("busy on d7", 32'h0000_0002, {pdata_oe, pdata_o[7]});
      n = 0;
      while (ready !== 1'b1 && n < 400)
      begin
         @(posedge mclk);
         n++;
      end
      repeat (4) @(posedge mclk);
      chk("ready on d7", 32'h0000_0003, {pdata_oe, pdata_o[7]});
      rs_n <= 1'b1;
      cs_n <= 1'b1;
      chk("byte irq", 1, irq);
      bus(REG_MASK, 1'b1, 32'h0, v);
      @(posedge mclk);
      chk("irq masked", 0, irq);
      bus(REG_MASK, 1'b1, 32'h0000_0004, v);
      bus(REG_IRQ, 1'b1, 32'h0000_0004, v);
      bus(REG_IRQ, 1'b0, 32'h0, v);
      chk("byte event cleared", 0, v[2]);
      chk("irq cleared", 0, irq);
   endtask

   // Master modes: the device makes its own clock; master serial walks to the finish, master parallel advances the address.
   task automatic master_modes();
      int n;
      do_reset();
      mode <= 3'h0;
      dccl_lead_inst.load(STREAM);
      init_done <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("clock enable master", 1, configuration_clock_oe);
      n = 0;
      while (rb_ok !== 1'b1 && n < 3000)
      begin
         @(posedge mclk);
         n++;
      end
      chk("master finish", 1, rb_ok);
      do_reset();
      n = n_adv;
      mode <= 3'h4;
      init_done <= 1'b1;
      repeat (400) @(posedge mclk);
      chk("address advanced", 1, n_adv > n + 1);
   endtask

   ////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] v;
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      init_done = 1'b0;
      mode = 3'h7;
      m1_user = 1'b0;
      m1_user_oe = 1'b1;
      pdata = 8'h00;
      cs_n = 1'b1;
      ws_n = 1'b1;
      rs_n = 1'b1;
      mismatches = 0;
      n_tests = 0;
      n_adv = 0;
      do_reset();
      bus(REG_CTRL, 1'b0, 32'h0, v);
      chk("own count default", {8'h00, OWN_BITS_DEF}, v);
      bus(4'h2, 1'b1, 32'hFFFF_FFFF, v);
      bus(4'h2, 1'b0, 32'h0, v);
      chk("unmapped read", 0, v);
      load_slave(52, 1'b1, 1'b0);
      bus(REG_IRQ, 1'b0, 32'h0, v);
      chk("match and finish events", 32'h0000_0003, v & 32'h0000_0003);
      chk("irq without mask", 0, irq);
      @(posedge mclk);
      m1_user <= 1'b1;
      @(posedge mclk);
      chk("mode1 out", 1, mode1_o);
      chk("mode1 enable", 1, mode1_oe);
      m1_user_oe <= 1'b0;
      @(posedge mclk);
      chk("mode1 enable off", 0, mode1_oe);
      m1_user_oe <= 1'b1;
      load_slave(51, 1'b0, 1'b0);
      load_slave(51, 1'b1, 1'b1);
      async_periph();
      master_modes();
      wrap_up();
   end
endmodule
`default_nettype wire
